// >>> hdl/csm_core_scratch_memory_control.sv
// Purpose: Control of a 2048-word, 16-bit erasable core scratch memory
// Assumes: APB master; one access per memory cycle; stop/jam/clamp by register
// Notes:   A cycle is a destructive read; only a write cycle then writes the buffer register
//
// Design decisions made here: the register addresses and register access over APB.
module csm_core_scratch_memory_control
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Memory status outputs
  output logic             timingHalt,
  output logic             ropeBlock,
  output logic             cycleBusy
);
  import csm_pkg::*;

  logic [11:0]    addrReg;
  logic [2:0]     bankReg;
  logic [15:0]    bufReg;
  logic [15:0]    rdataReg;
  logic [4:0]     ctrlReg;
  logic [3:0]     subiReg;
  logic [CNT_W-1:0] cntReg;
  csm_state_e     stateReg;
  logic           selReg;
  logic [5:0]     xSelReg;
  logic [4:0]     ySelReg;
  logic           doneReg;
  logic           refusedReg;
  logic [15:0]    mem [0:2047];

  // Bus decode
  wire busWr   = psel && penable && pwrite;
  wire goWr    = busWr && (paddr == OFF_CTRL) && pwdata[CTRL_GO];
  wire mapped  = (paddr == OFF_ADDR) || (paddr == OFF_BANK) || (paddr == OFF_WDATA)
              || (paddr == OFF_CTRL) || (paddr == OFF_STATUS) || (paddr == OFF_RDATA);

  // Halt, jam and clamp controls
  wire stopIn   = ctrlReg[CTRL_STOP];
  wire jamIn    = ctrlReg[CTRL_JAM];
  wire clampIn  = ctrlReg[CTRL_CLAMP];
  wire haltSig  = stopIn;

  // Address decode
  wire scratchSel = (addrReg[11:10] == 2'b00);
  wire lowFlag    = (addrReg < LOW_LIMIT);
  wire [2:0] bankNum = (addrReg[9:8] == 2'b00) ? 3'h0 :
                       (addrReg[9:8] == 2'b01) ? 3'h1 :
                       (addrReg[9:8] == 2'b10) ? 3'h2 :
                       bankReg;
  // Eight banks of 256 words give an 11-bit word index
  wire [10:0] wordIdx = {bankNum, addrReg[7:0]};
  wire [5:0]  xDec    = wordIdx[10:5];
  wire [4:0]  yDec    = wordIdx[4:0];
  // Cycle enable
  wire cycleEn = scratchSel && (subiReg == 4'h0) && !lowFlag && !clampIn;

  // Phase strobes: set/reset killed by halt, sense/write by jam
  wire busy       = (stateReg != CSM_IDLE);
  wire setStrobe  = busy && !haltSig && (cntReg == CNT_W'(SET_AT));
  wire senseStb   = busy && !jamIn && (cntReg == CNT_W'(SENSE_AT));
  wire resetStb   = busy && !haltSig && (cntReg == CNT_W'(RESET_AT));
  wire writeStb   = busy && !jamIn && (stateReg == CSM_WRITE)
                 && (cntReg == CNT_W'(WRITE_AT));
  wire cycleEnd   = busy && (cntReg == CNT_W'(CYCLE_CLKS - 1));
  wire [10:0] selIdx = {xSelReg, ySelReg};

  // Written word: inhibited planes stay zero
  wire [15:0] inhibit  = ~bufReg;
  wire [15:0] writeVal = 16'hFFFF & ~inhibit;

  // Read mux
  logic [31:0] rdMux;
  always_comb
  begin
    rdMux = 32'h0000_0000;
    case (paddr)
      OFF_ADDR:   rdMux = {20'h0, addrReg};
      OFF_BANK:   rdMux = {29'h0, bankReg};
      OFF_WDATA:  rdMux = {16'h0, bufReg};
      OFF_CTRL:   rdMux = {20'h0, subiReg, 3'h0, ctrlReg[4:1], 1'b0};
      OFF_STATUS: rdMux = {24'h0, refusedReg, doneReg, lowFlag, scratchSel,
                           cycleEn, haltSig, busy, selReg};
      OFF_RDATA:  rdMux = {16'h0, rdataReg};
      default:    rdMux = 32'h0000_0000;
    endcase
  end

  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !mapped;
  assign timingHalt = haltSig;
  assign ropeBlock  = haltSig;
  assign cycleBusy  = busy;

  // Read data register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= rdMux;
  end

  // Software registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      addrReg <= ADDR_RST;
      bankReg <= BANK_RST;
      ctrlReg <= 5'h00;
      subiReg <= 4'h0;
    end
    else if (busWr)
    begin
      if (paddr == OFF_ADDR && !busy)
        addrReg <= pwdata[11:0];
      if (paddr == OFF_BANK)
        bankReg <= pwdata[2:0];
      if (paddr == OFF_CTRL)
      begin
        ctrlReg <= {pwdata[4:1], 1'b0};
        subiReg <= pwdata[CTRL_SUBI+3:CTRL_SUBI];
      end
    end
  end

  // Cycle sequencer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stateReg <= CSM_IDLE;
      cntReg   <= '0;
    end
    else if (haltSig)
    begin
      stateReg <= CSM_IDLE;
      cntReg   <= '0;
    end
    else
    begin
      case (stateReg)
        CSM_IDLE:
        begin
          cntReg <= '0;
          if (goWr && cycleEn)
            stateReg <= pwdata[CTRL_WRITE] ? CSM_WRITE : CSM_READ;
        end
        CSM_READ, CSM_WRITE:
        begin
          cntReg <= cntReg + CNT_W'(1);
          if (cycleEnd)
            stateReg <= CSM_IDLE;
        end
        default: stateReg <= CSM_IDLE;
      endcase
    end
  end

  // Selection switches latched on set, released on reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      selReg  <= 1'b0;
      xSelReg <= 6'h00;
      ySelReg <= 5'h00;
    end
    else if (setStrobe)
    begin
      selReg  <= 1'b1;
      xSelReg <= xDec;
      ySelReg <= yDec;
    end
    else if (resetStb || haltSig)
      selReg  <= 1'b0;
  end

  // Buffer register and status flags
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bufReg     <= DATA_RST;
      rdataReg   <= DATA_RST;
      doneReg    <= 1'b0;
      refusedReg <= 1'b0;
    end
    else
    begin
      if (senseStb && selReg)
      begin
        bufReg   <= mem[selIdx];
        rdataReg <= mem[selIdx];
      end
      else if (busWr && paddr == OFF_WDATA)
        bufReg <= pwdata[15:0];
      if (cycleEnd)
        doneReg <= 1'b1;
      else if (goWr)
        doneReg <= 1'b0;
      // A start that the halt drops is reported as refused too
      if (goWr && (!cycleEn || busy || haltSig))
        refusedReg <= 1'b1;
      else if (goWr)
        refusedReg <= 1'b0;
    end
  end

  // Core array: sense clears the word, a write cycle then stores the buffer register
  always_ff @(posedge clk)
  begin
    if (senseStb && selReg)
      mem[selIdx] <= 16'h0000;
    else if (writeStb)
      mem[selIdx] <= writeVal;
  end
endmodule

// >>> hdl/csm_pkg.sv
// Purpose: Constants for the core scratch memory control block
// Assumes: 250 MHz clock, 32-bit APB register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
package csm_pkg;
  localparam int unsigned    CLK_MHZ        = 250;
  // Memory cycle length in nanoseconds and its cycle count
  localparam int unsigned    CYCLE_NS       = 11970;
  localparam int unsigned    CYCLE_CLKS     = (CYCLE_NS * CLK_MHZ) / 1000;
  // Phase points inside one memory cycle, in clocks
  localparam int unsigned    SET_AT         = 8;
  localparam int unsigned    SENSE_AT       = CYCLE_CLKS / 4;
  localparam int unsigned    RESET_AT       = CYCLE_CLKS / 2;
  localparam int unsigned    WRITE_AT       = (CYCLE_CLKS * 3) / 4;
  localparam int unsigned    CNT_W          = 12;
  // Register offsets
  localparam logic [7:0]     OFF_ADDR       = 8'h00;
  localparam logic [7:0]     OFF_BANK       = 8'h04;
  localparam logic [7:0]     OFF_WDATA      = 8'h08;
  localparam logic [7:0]     OFF_CTRL       = 8'h0C;
  localparam logic [7:0]     OFF_STATUS     = 8'h10;
  localparam logic [7:0]     OFF_RDATA      = 8'h14;
  // Control fields
  localparam int unsigned    CTRL_GO        = 0;
  localparam int unsigned    CTRL_WRITE     = 1;
  localparam int unsigned    CTRL_STOP      = 2;
  localparam int unsigned    CTRL_JAM       = 3;
  localparam int unsigned    CTRL_CLAMP     = 4;
  localparam int unsigned    CTRL_SUBI      = 8;
  // Reset values
  localparam logic [11:0]    ADDR_RST       = 12'h000;
  localparam logic [2:0]     BANK_RST       = 3'h0;
  localparam logic [15:0]    DATA_RST       = 16'h0000;
  // Low address limit (octal 0007)
  localparam logic [11:0]    LOW_LIMIT      = 12'h007;
  typedef enum logic [1:0] {
    CSM_IDLE  = 2'b00,
    CSM_READ  = 2'b01,
    CSM_WRITE = 2'b10
  } csm_state_e;
endpackage

// >>> tb/csm_cpu_model.sv
// Purpose: Processor side decode and word shadow
// Assumes: Bank register used when bits 9:8 are both set
// Notes:   Words are known only once written
module csm_cpu_model;
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [2048];
  // Word index from address and bank register
  function automatic logic [10:0] idx(input logic [11:0] a, input logic [2:0] b);
    return {(a[9:8] == 2'b11) ? b : {1'b0, a[9:8]}, a[7:0]};
  endfunction
  // Low flag, selection and cycle enable
  function automatic logic [2:0] dec(input logic [11:0] a);
    return {a < 12'h007, a[11:10] == 2'b00, a[11:10] == 2'b00 && a >= 12'h007};
  endfunction
endmodule

// >>> tb/csm_props_properties.sv
// Purpose: Port checks for scratch memory control
// Assumes: One clock, async active-high reset
// Notes:   Bound to the top module
module csm_props
  import csm_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timingHalt,
  input wire logic        ropeBlock,
  input wire logic        cycleBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] busyCnt_reg;
  logic        goWr_reg;
  wire         ctrlWr = psel & penable & pwrite & (paddr == OFF_CTRL);
  // Busy run length and GO write trace
  always_ff @(posedge clk or posedge rst)
    if (rst)
      busyCnt_reg <= 12'h000;
    else
      busyCnt_reg <= cycleBusy ? busyCnt_reg + 12'h001 : 12'h000;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      goWr_reg <= 1'b0;
    else
      goWr_reg <= ctrlWr & pwdata[CTRL_GO];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_stopWr; ctrlWr && pwdata[CTRL_STOP]; endsequence
  sequence s_bad; psel && penable && (paddr > OFF_RDATA || paddr[1:0] != 2'b00); endsequence
  property p_ready; pready; endproperty
  property p_rope; ropeBlock == timingHalt; endproperty
  property p_halt; s_stopWr |=> timingHalt; endproperty
  property p_idle; timingHalt |=> !cycleBusy; endproperty
  property p_len; $fell(cycleBusy) && !timingHalt |-> busyCnt_reg == 12'hBB0; endproperty
  property p_start; $rose(cycleBusy) |-> goWr_reg; endproperty
  property p_err; s_bad |-> pslverr; endproperty
  property p_upper; psel && penable && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_rope: assert property (p_rope) else $error("rope block differs");
  a_halt: assert property (p_halt) else $error("halt missing");
  a_idle: assert property (p_idle) else $error("busy under halt");
  a_len: assert property (p_len) else $error("cycle length wrong");
  a_start: assert property (p_start) else $error("cycle without GO");
  a_err: assert property (p_err) else $error("no slave error");
  a_upper: assert property (p_upper) else $error("upper read bits set");
endmodule
bind csm_core_scratch_memory_control csm_props u_props (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timingHalt(timingHalt), .ropeBlock(ropeBlock),
  .cycleBusy(cycleBusy));

// >>> tb/tb.sv
// Purpose: Self-checking bench for scratch memory control
// Assumes: 4 ns clock, reset held 20 cycles
// Notes:   Expected words kept in the processor model
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import csm_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic        timingHalt, ropeBlock, cycleBusy;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] seed;
  logic [11:0] a;
  logic [11:0] tabA [7] = '{12'h000, 12'h006, 12'h007, 12'h3FF, 12'h400, 12'h800, 12'hC00};
  logic [11:0] tabR [5] = '{12'h123, 12'h123, 12'h123, 12'h003, 12'h800};
  logic [31:0] tabC [5] = '{32'h5, 32'h11, 32'h101, 32'h1, 32'h1};
  int          bad_count, comparisons;
  csm_cpu_model cpu ();
  csm_core_scratch_memory_control DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timingHalt(timingHalt), .ropeBlock(ropeBlock), .cycleBusy(cycleBusy));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // APB transfer, held until pready
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // One memory cycle; a write loads the buffer after sensing
  task automatic cyc(input logic [11:0] ad, input logic [2:0] b, input logic w, input logic [15:0] v);
    bus(1'b1, OFF_ADDR, {20'h0, ad});
    bus(1'b1, OFF_BANK, {29'h0, b});
    bus(1'b1, OFF_CTRL, {30'h0, w, 1'b1});
    chk({31'h0, cycleBusy}, 32'h1);
    if (w)
    begin
      repeat (760) @(posedge clk);
      bus(1'b1, OFF_WDATA, {16'h0, v});
    end
    while (cycleBusy === 1'b1)
      @(posedge clk);
    bus(1'b0, OFF_RDATA, 32'h0);
    if (!w)
      chk(rd, {16'h0, cpu.mem[cpu.idx(ad, b)]});
    cpu.mem[cpu.idx(ad, b)] = w ? v : 16'h0000;
  endtask
  task automatic summarize();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (95000) @(posedge clk);
    bad_count++;
    summarize();
  end
  // Main sequence
  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h00, 32'h0};
    {bad_count, comparisons, seed} = {32'h0, 32'h0, 16'd55300};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (tabA[i])
    begin
      bus(1'b1, OFF_ADDR, {20'h0, tabA[i]});
      bus(1'b0, OFF_STATUS, 32'h0);
      chk({29'h0, rd[5:3]}, {29'h0, cpu.dec(tabA[i])});
    end
    bus(1'b0, 8'h18, 32'h0);
    chk({31'h0, er}, 32'h1);
    // Write through the bank register, read back by direct bank where possible
    for (int k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      a = {4'h3, seed[7:0] | 8'h08};
      cyc(a, k[2:0], 1'b1, seed);
      if (k < 3)
        a = {2'b00, k[1:0], a[7:0]};
      cyc(a, (k < 3) ? ~k[2:0] : k[2:0], 1'b0, 16'h0);
    end
    cyc(a, 3'h7, 1'b0, 16'h0);
    // Stop a read cycle three clocks in, before its set phase, then starts that must be refused
    bus(1'b1, OFF_ADDR, 32'h123);
    bus(1'b1, OFF_CTRL, 32'h1);
    bus(1'b1, OFF_CTRL, 32'h4);
    @(negedge clk);
    chk({30'h0, timingHalt, cycleBusy}, 32'h2);
    foreach (tabC[i])
    begin
      bus(1'b1, OFF_ADDR, {20'h0, tabR[i]});
      bus(1'b1, OFF_CTRL, tabC[i]);
      bus(1'b0, OFF_STATUS, 32'h0);
      chk({30'h0, rd[7], rd[1]}, 32'h2);
    end
    summarize();
  end
endmodule
